/* rtl/i2c_bus_pkg.sv */
`default_nettype none
package i2c_bus_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL1 = 8'h00;
   localparam logic [7:0] OFS_CTRL2 = 8'h04;
   localparam logic [7:0] OFS_STAT = 8'h08;
   localparam logic [7:0] OFS_DATA = 8'h0c;
   localparam logic [7:0] OFS_OWN = 8'h10;
   localparam logic [7:0] OFS_DIV = 8'h14;
   localparam logic [7:0] OFS_IDLE = 8'h18;
   // field positions
   localparam int CTRL1_BPW = 5;
   localparam int CTRL1_NINTH = 4;
   localparam int CTRL2_CMD = 4;
   localparam int CTRL2_MODE = 2;
   // command, mode and reset codes
   localparam logic [3:0] CMD_START = 4'hf;
   localparam logic [3:0] CMD_STOP = 4'hd;
   localparam logic [1:0] MODE_BUS = 2'h2;
   localparam logic [1:0] SRST_ARM = 2'h2;
   localparam logic [1:0] SRST_FIRE = 2'h1;
   localparam logic [1:0] SRST_IDLE = 2'h0;
   localparam logic [3:0] FULL_WORD = 4'h8;
   // clock cycles per half bus clock at divider setting zero
   localparam int HALF_BASE_DEF = 8;

   typedef enum logic [2:0] {
      st_idle, st_start, st_run, st_stop_low, st_stop_rise
   } master_state_type;

   typedef struct packed {
      logic scl;
      logic sda;
   } pins_type;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } apb_req_type;

   typedef struct packed {
      logic master_select, transmit_select, bus_busy_flag;
      logic pending_release_flag, al, aas, ad0, lrb;
      logic ninth_clock_enable, reset_done_monitor, armed;
      logic [2:0] bits_per_word, clock_divider_select;
      logic [1:0] interface_mode_select, soft_reset_code;
      logic format_select, prescaler_enable, idle_run_select;
      logic [6:0] own_slave_address;
      logic [7:0] shift;
      logic [3:0] cnt;
      logic first, match;
      master_state_type ms;
      logic [15:0] div;
      logic scl_oe, sda_oe, tirq, sirq;
   } core_type;

   localparam core_type CORE_RST = '{pending_release_flag: 1'b1,
      reset_done_monitor: 1'b1, ms: st_idle, default: '0};
endpackage : i2c_bus_pkg
`default_nettype wire

/* rtl/i2c_bus_interface.sv */
`default_nettype none
// Notes on behaviour
// - code 10 then 01 fires internal reset
// - soft reset clears all but mode select
// - reset code returns to 00 by itself
// - reset done monitor readable in control one
// - data buffer: rx byte, tx byte, address
// - seven-bit own address recognises slave accesses
// - addressing format: direction bit sets transmit select
// - free format: all data, no address match
// - idle run select keeps block running idle
// - command 1111 while bus free starts
// - nine clocks, address out, release ninth
// - ninth fall: irq, release flag cleared, hold
// - master direction follows only after acknowledge
// - slave acks own address or general call
// - data write as transmitter clocks next word
// - data read as receiver clocks, acks word
// - one-bit read with line high, stop
// - data line caught at each clock rise
// - busy set on start, cleared on stop
module i2c_bus_interface #(
   parameter int HALF_BASE = i2c_bus_pkg::HALF_BASE_DEF
) (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic en_in,
   input wire logic idle_in,
   input wire i2c_bus_pkg::apb_req_type apb_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic scl_in,
   input wire logic sda_in,
   output i2c_bus_pkg::pins_type bus_out,
   output i2c_bus_pkg::pins_type bus_oe_out,
   output logic transfer_irq_out,
   output logic stop_irq_out
);
   i2c_bus_pkg::core_type core_reg, core_next;
   logic scl_meta_reg, scl_sync_reg, scl_last_reg;
   logic sda_meta_reg, sda_sync_reg, sda_last_reg;
   logic pready_reg, pready_next, pslverr_reg, pslverr_next;
   logic [31:0] prdata_reg, prdata_next, wdat;
   logic rise, fall, start_det, stop_det, acc, wr, rd, run;
   logic txing, ackme, owned, done;
   logic [3:0] wl, total;
   logic [15:0] half;

   // half bus clock in system cycles for a divider setting
   function automatic logic [15:0] half_cycles(input logic [2:0] sel);
      return 16'(HALF_BASE) << sel;
   endfunction : half_cycles

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers; only the second stage and later are read
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         scl_meta_reg <= 1'b1;
         scl_sync_reg <= 1'b1;
         scl_last_reg <= 1'b1;
         sda_meta_reg <= 1'b1;
         sda_sync_reg <= 1'b1;
         sda_last_reg <= 1'b1;
      end else if (en_in) begin
         scl_meta_reg <= scl_in;
         scl_sync_reg <= scl_meta_reg;
         scl_last_reg <= scl_sync_reg;
         sda_meta_reg <= sda_in;
         sda_sync_reg <= sda_meta_reg;
         sda_last_reg <= sda_sync_reg;
      end
   end

   // bus edges and conditions seen on the synchronised lines
   assign rise = scl_sync_reg & ~scl_last_reg;
   assign fall = ~scl_sync_reg & scl_last_reg;
   assign start_det = scl_sync_reg & scl_last_reg & sda_last_reg
      & ~sda_sync_reg;
   assign stop_det = scl_sync_reg & scl_last_reg & ~sda_last_reg
      & sda_sync_reg;

   ////////////////////////////////////////////////////////////////////
   // apb slave: one wait state, so read data is settled with pready
   assign acc = apb_in.psel & apb_in.penable & pready_reg;
   assign wr = acc & apb_in.pwrite;
   assign rd = acc & ~apb_in.pwrite;
   assign wdat = apb_in.pwdata;

   always_comb begin
      pready_next = apb_in.psel & apb_in.penable & ~pready_reg;
      prdata_next = prdata_reg;
      pslverr_next = pslverr_reg;
      if (pready_next) begin
         prdata_next = 32'h0;
         pslverr_next = 1'b0;
         unique case (apb_in.paddr)
            i2c_bus_pkg::OFS_CTRL1: prdata_next[7:0] = {
               core_reg.bits_per_word, core_reg.ninth_clock_enable,
               core_reg.reset_done_monitor,
               core_reg.clock_divider_select};
            i2c_bus_pkg::OFS_CTRL2: prdata_next[7:0] = {
               core_reg.master_select, core_reg.transmit_select,
               core_reg.bus_busy_flag, core_reg.pending_release_flag,
               core_reg.interface_mode_select,
               core_reg.soft_reset_code};
            i2c_bus_pkg::OFS_STAT: prdata_next[7:0] = {
               core_reg.master_select, core_reg.transmit_select,
               core_reg.bus_busy_flag, core_reg.pending_release_flag,
               core_reg.al, core_reg.aas, core_reg.ad0, core_reg.lrb};
            i2c_bus_pkg::OFS_DATA: prdata_next[7:0] = core_reg.shift;
            i2c_bus_pkg::OFS_OWN: prdata_next[7:0] = {
               core_reg.own_slave_address, core_reg.format_select};
            i2c_bus_pkg::OFS_DIV:
               prdata_next[0] = core_reg.prescaler_enable;
            i2c_bus_pkg::OFS_IDLE:
               prdata_next[0] = core_reg.idle_run_select;
            default: pslverr_next = 1'b1; // unmapped address
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         pready_reg <= 1'b0;
         prdata_reg <= 32'h0;
         pslverr_reg <= 1'b0;
      end else if (en_in) begin
         pready_reg <= pready_next;
         prdata_reg <= prdata_next;
         pslverr_reg <= pslverr_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // word framing helpers
   assign wl = (core_reg.bits_per_word == 3'h0) ? i2c_bus_pkg::FULL_WORD
      : {1'b0, core_reg.bits_per_word};
   assign total = core_reg.ninth_clock_enable ? wl + 4'h1 : wl;
   assign half = half_cycles(core_reg.clock_divider_select);
   assign run = (core_reg.interface_mode_select == i2c_bus_pkg::MODE_BUS)
      & (~idle_in | core_reg.idle_run_select);
   assign txing = core_reg.master_select
      ? (core_reg.first | core_reg.transmit_select)
      : (core_reg.transmit_select & core_reg.aas);
   assign ackme = core_reg.first ? core_reg.match
      : (~core_reg.transmit_select & (core_reg.master_select
      | core_reg.aas | core_reg.format_select));
   assign owned = core_reg.master_select | core_reg.aas | core_reg.match
      | core_reg.format_select;
   assign done = run & core_reg.bus_busy_flag & ~start_det & ~stop_det
      & fall & (core_reg.cnt == total);

   // register side effects, line drive, master sequencer, bus events
   always_comb begin
      core_next = core_reg;
      core_next.tirq = 1'b0;
      core_next.sirq = 1'b0;
      if (wr) begin
         unique case (apb_in.paddr)
            i2c_bus_pkg::OFS_CTRL1: begin
               core_next.bits_per_word = wdat[i2c_bus_pkg::CTRL1_BPW+:3];
               core_next.ninth_clock_enable =
                  wdat[i2c_bus_pkg::CTRL1_NINTH];
               core_next.clock_divider_select = wdat[2:0];
            end
            i2c_bus_pkg::OFS_CTRL2: begin
               core_next.al = 1'b0;
               core_next.interface_mode_select =
                  wdat[i2c_bus_pkg::CTRL2_MODE+:2];
               if (wdat[i2c_bus_pkg::CTRL2_CMD+:4] == i2c_bus_pkg::CMD_START
                  && !core_reg.bus_busy_flag) begin
                  core_next.master_select = 1'b1;
                  core_next.transmit_select = 1'b1;
                  core_next.pending_release_flag = 1'b1;
                  core_next.ms = i2c_bus_pkg::st_start;
                  core_next.div = 16'h0;
               end else if (wdat[i2c_bus_pkg::CTRL2_CMD+:4]
                  == i2c_bus_pkg::CMD_STOP && core_reg.bus_busy_flag
                  && core_reg.master_select) begin
                  core_next.ms = i2c_bus_pkg::st_stop_low;
                  core_next.div = 16'h0;
               end else begin
                  core_next.master_select = wdat[7];
                  core_next.transmit_select = wdat[6];
                  if (wdat[4])
                     core_next.pending_release_flag = 1'b1;
               end
               // two-step unlock keeps a stray write from resetting
               core_next.armed = 1'b0;
               core_next.soft_reset_code = i2c_bus_pkg::SRST_IDLE;
               if (wdat[1:0] == i2c_bus_pkg::SRST_ARM) begin
                  core_next.armed = 1'b1;
                  core_next.soft_reset_code = i2c_bus_pkg::SRST_ARM;
               end else if (wdat[1:0] == i2c_bus_pkg::SRST_FIRE
                  && core_reg.armed) begin
                  core_next.soft_reset_code = i2c_bus_pkg::SRST_FIRE;
                  core_next.reset_done_monitor = 1'b0;
               end
            end
            i2c_bus_pkg::OFS_DATA: begin
               core_next.shift = wdat[7:0];
               core_next.pending_release_flag = 1'b1;
               core_next.al = 1'b0;
               core_next.aas = 1'b0;
            end
            i2c_bus_pkg::OFS_OWN: begin
               core_next.own_slave_address = wdat[7:1];
               core_next.format_select = wdat[0];
            end
            i2c_bus_pkg::OFS_DIV: core_next.prescaler_enable = wdat[0];
            i2c_bus_pkg::OFS_IDLE: core_next.idle_run_select = wdat[0];
            default: ;
         endcase
      end
      if (rd && apb_in.paddr == i2c_bus_pkg::OFS_DATA) begin
         core_next.pending_release_flag = 1'b1;
         core_next.al = 1'b0;
         core_next.aas = 1'b0;
      end
      if (run) begin
         // data and acknowledge drive changes only while the clock is low
         core_next.scl_oe = ~core_reg.pending_release_flag
            & ~core_reg.master_select & core_reg.bus_busy_flag;
         if (!scl_sync_reg)
            core_next.sda_oe = core_reg.bus_busy_flag
               & ((core_reg.cnt < wl) ? (txing & ~core_reg.shift[7])
               : ((core_reg.cnt == wl) & core_reg.ninth_clock_enable
               & ackme));
         if (core_reg.prescaler_enable) begin
            unique case (core_reg.ms)
               i2c_bus_pkg::st_idle: ;
               i2c_bus_pkg::st_start: begin
                  core_next.scl_oe = 1'b0;
                  core_next.sda_oe = 1'b1;
                  core_next.div = core_reg.div + 16'h1;
                  if (core_reg.div >= half) begin
                     core_next.ms = i2c_bus_pkg::st_run;
                     core_next.scl_oe = 1'b1;
                     core_next.div = 16'h0;
                  end
               end
               i2c_bus_pkg::st_run: begin
                  core_next.scl_oe = core_reg.scl_oe;
                  core_next.div = core_reg.div + 16'h1;
                  if (core_reg.scl_oe) begin
                     // low time counts from the release flag being set
                     if (!core_reg.pending_release_flag)
                        core_next.div = 16'h0;
                     else if (core_reg.div >= half) begin
                        core_next.scl_oe = 1'b0;
                        core_next.div = 16'h0;
                     end
                  end else if (!scl_sync_reg)
                     core_next.div = 16'h0; // another party stretches
                  else if (core_reg.div >= half) begin
                     core_next.scl_oe = 1'b1;
                     core_next.div = 16'h0;
                  end
               end
               i2c_bus_pkg::st_stop_low: begin
                  core_next.scl_oe = 1'b1;
                  core_next.sda_oe = 1'b1;
                  core_next.div = core_reg.div + 16'h1;
                  if (core_reg.div >= half) begin
                     core_next.ms = i2c_bus_pkg::st_stop_rise;
                     core_next.scl_oe = 1'b0;
                     core_next.div = 16'h0;
                  end
               end
               i2c_bus_pkg::st_stop_rise: begin
                  core_next.scl_oe = 1'b0;
                  core_next.sda_oe = 1'b1;
                  if (scl_sync_reg)
                     core_next.div = core_reg.div + 16'h1;
                  if (core_reg.div >= half) begin
                     core_next.ms = i2c_bus_pkg::st_idle;
                     core_next.sda_oe = 1'b0;
                     core_next.div = 16'h0;
                  end
               end
               default: core_next.ms = i2c_bus_pkg::st_idle;
            endcase
         end
         if (start_det) begin
            core_next.bus_busy_flag = 1'b1;
            core_next.cnt = 4'h0;
            core_next.first = 1'b1;
            core_next.match = 1'b0;
            core_next.ad0 = 1'b0;
         end else if (stop_det) begin
            core_next.sirq = core_reg.bus_busy_flag;
            core_next.bus_busy_flag = 1'b0;
            core_next.master_select = 1'b0;
            core_next.transmit_select = 1'b0;
            core_next.ad0 = 1'b0;
            core_next.ms = i2c_bus_pkg::st_idle;
         end else if (core_reg.bus_busy_flag) begin
            if (rise) begin
               core_next.cnt = core_reg.cnt + 4'h1;
               core_next.lrb = sda_sync_reg;
               if (core_reg.cnt < wl) begin
                  core_next.shift = {core_reg.shift[6:0], sda_sync_reg};
                  // released high but read low: another master won
                  if (core_reg.master_select && txing
                     && core_reg.shift[7] && !sda_sync_reg) begin
                     core_next.al = 1'b1;
                     core_next.master_select = 1'b0;
                     core_next.transmit_select = 1'b0;
                  end
               end
            end
            if (fall && core_reg.cnt == wl)
               core_next.match = ~core_reg.master_select
                  & ~core_reg.format_select & core_reg.first
                  & ((core_reg.shift[7:1] == core_reg.own_slave_address)
                  | (core_reg.shift == 8'h0));
            if (done) begin
               core_next.cnt = 4'h0;
               core_next.first = 1'b0;
               if (owned) begin
                  core_next.tirq = 1'b1;
                  core_next.pending_release_flag = 1'b0;
               end
               if (core_reg.first && !core_reg.format_select) begin
                  if (core_reg.master_select) begin
                     if (!core_reg.lrb)
                        core_next.transmit_select = ~core_reg.shift[0];
                  end else if (core_reg.match) begin
                     core_next.transmit_select = core_reg.shift[0];
                     core_next.aas = 1'b1;
                     core_next.ad0 = (core_reg.shift == 8'h0);
                  end
               end else if (core_reg.first && !core_reg.master_select)
                  core_next.aas = 1'b1;
               if (!core_reg.master_select)
                  core_next.ms = i2c_bus_pkg::st_idle;
            end
         end
      end
      if (core_reg.interface_mode_select != i2c_bus_pkg::MODE_BUS) begin
         core_next.scl_oe = 1'b0;
         core_next.sda_oe = 1'b0;
      end
      // soft reset pulse: everything but the mode field, code back to 00
      if (!core_reg.reset_done_monitor) begin
         core_next = i2c_bus_pkg::CORE_RST;
         core_next.interface_mode_select = core_reg.interface_mode_select;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!nrst_in)
         core_reg <= i2c_bus_pkg::CORE_RST;
      else if (en_in)
         core_reg <= core_next;
   end

   // open-drain pins only ever pull low
   assign bus_out = '0;
   assign bus_oe_out = '{scl: core_reg.scl_oe, sda: core_reg.sda_oe};
   assign transfer_irq_out = core_reg.tirq;
   assign stop_irq_out = core_reg.sirq;
   assign prdata_out = prdata_reg;
   assign pready_out = pready_reg;
   assign pslverr_out = pslverr_reg;

   ////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);

   a_soft_rst_end: assert property (
      en_in && !core_reg.reset_done_monitor |=> core_reg.reset_done_monitor
      && core_reg.soft_reset_code == 2'h0)
      else $error("soft reset did not complete");
   a_mode_kept: assert property (
      en_in && !core_reg.reset_done_monitor |=>
      $stable(core_reg.interface_mode_select) && !core_reg.master_select)
      else $error("soft reset lost mode or kept master");
   a_irq_flag: assert property (
      core_reg.tirq |-> !core_reg.pending_release_flag)
      else $error("transfer irq without release flag cleared");
   a_hold_scl: assert property (
      en_in && run && core_reg.ms == i2c_bus_pkg::st_run && core_reg.scl_oe
      && !core_reg.pending_release_flag && !wr && !rd |=> core_reg.scl_oe)
      else $error("clock line released while flag low");
   a_busy_start: assert property (
      en_in && run && start_det |=> core_reg.bus_busy_flag [*2])
      else $error("start not flagged busy");
   a_bit_capture: assert property (
      en_in && run && rise && core_reg.bus_busy_flag && !start_det
      && !stop_det |=> core_reg.lrb == $past(sda_sync_reg))
      else $error("last bit not captured");
   a_start_cmd: assert property (
      en_in && wr && apb_in.paddr == i2c_bus_pkg::OFS_CTRL2
      && apb_in.pwdata[7:4] == 4'hf && !core_reg.bus_busy_flag
      && core_reg.reset_done_monitor |=> core_reg.master_select
      && core_reg.ms == i2c_bus_pkg::st_start)
      else $error("start command not taken");
   a_free_format: assert property (
      en_in && done && core_reg.format_select && core_reg.first
      |=> core_reg.transmit_select == $past(core_reg.transmit_select))
      else $error("direction changed in free format");
   a_data_write: assert property (
      en_in && wr && apb_in.paddr == i2c_bus_pkg::OFS_DATA && !done
      && core_reg.reset_done_monitor |=> core_reg.pending_release_flag
      && core_reg.shift == $past(apb_in.pwdata[7:0]))
      else $error("data write did not arm transfer");
endmodule : i2c_bus_interface
`default_nettype wire

/* verification/i2c_slave_model.sv */
`default_nettype none
// far-side slave: shifts each word in, acks its address and later words of a write
module i2c_slave_model #(
   parameter logic [6:0] ADDR = 7'h50
) (
   input wire logic clk_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_oe_out,
   output logic [7:0] byte_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic scl_d = 1'b1, sda_d = 1'b1, hit = 1'b0, rdir = 1'b0;
   logic [3:0] cnt = 4'h0;
   logic [7:0] sh = 8'h00;
   initial sda_oe_out = 1'b0;
   initial byte_out = 8'h00;
   // sampled on the system clock, so line edges are seen a cycle late
   always @(posedge clk_in) begin
      scl_d <= scl_in;
      sda_d <= sda_in;
      if (scl_in && sda_d && !sda_in) begin
         cnt <= 4'h0; // start restarts framing
         hit <= 1'b0;
         rdir <= 1'b0;
      end else if (scl_in && !scl_d) begin
         cnt <= cnt + 4'h1;
         if (cnt < 4'h8) sh <= {sh[6:0], sda_in}; // msb first
      end else if (!scl_in && scl_d) begin
         if (cnt == 4'h8) begin
            byte_out <= sh;
            // a read from this slave leaves acknowledging to the master
            if ((hit && !rdir) || (!hit && sh[7:1] == ADDR)) begin
               sda_oe_out <= 1'b1;
               hit <= 1'b1;
            end
            if (!hit)
               rdir <= sh[0];
         end
         if (cnt == 4'h9) begin
            sda_oe_out <= 1'b0; // released: pull-up takes the line high
            cnt <= 4'h0;
         end
      end
   end
endmodule : i2c_slave_model
`default_nettype wire

/* verification/i2c_bus_interface_tb.sv */
`default_nettype none
module i2c_bus_interface_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in = 1'b0, nrst_in = 1'b0, en_in = 1'b1, idle_in = 1'b0;
   i2c_bus_pkg::apb_req_type apb_req = '0;
   i2c_bus_pkg::pins_type oe;
   logic [31:0] prdata;
   logic pready, perr, tirq, sirq, scl_w, sda_w, sl_oe, err_seen;
   logic [7:0] rx, sl_byte;
   int num_errors = 0, samples_checked = 0;
   // open-drain wires: low while anyone pulls
   assign scl_w = !oe.scl;
   assign sda_w = !(oe.sda || sl_oe);
   i2c_bus_interface #(.HALF_BASE(4)) dut (.clk_in(clk_in),
      .nrst_in(nrst_in), .en_in(en_in), .idle_in(idle_in),
      .apb_in(apb_req), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(perr), .scl_in(scl_w), .sda_in(sda_w), .bus_out(),
      .bus_oe_out(oe), .transfer_irq_out(tirq), .stop_irq_out(sirq));
   i2c_slave_model #(.ADDR(7'h50)) slave (.clk_in(clk_in), .scl_in(scl_w),
      .sda_in(sda_w), .sda_oe_out(sl_oe), .byte_out(sl_byte));
   ////////////////////////////////////////////////////////////////////
   task end_sim;
      if (num_errors == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : end_sim
   task chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // apb transfer; request held until pready is seen at a rising edge
   task apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_in);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a,
                   pwdata: {24'h0, d}};
      @(posedge clk_in);
      apb_req.penable <= 1'b1;
      do begin
         @(posedge clk_in);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rx = prdata[7:0];
      err_seen = perr;
      apb_req <= '0;
   endtask : apb
   // bounded wait for one of the two interrupt pulses
   task wait_irq(input logic stop);
      int n;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while ((stop ? sirq : tirq) !== 1'b1 && n < 3000);
      chk(8'(n < 3000), 8'h01);
   endtask : wait_irq
   ////////////////////////////////////////////////////////////////////
   task t_soft_reset;
      apb(1, i2c_bus_pkg::OFS_OWN, 8'ha0);
      apb(1, i2c_bus_pkg::OFS_CTRL2, 8'h0a);
      apb(1, i2c_bus_pkg::OFS_CTRL2, 8'h09);
      apb(0, i2c_bus_pkg::OFS_CTRL2, 8'h00);
      chk(rx, 8'h18); // mode kept, code back to 00
      apb(0, i2c_bus_pkg::OFS_OWN, 8'h00);
      chk(rx, 8'h00); // own address cleared
      apb(0, i2c_bus_pkg::OFS_CTRL1, 8'h00);
      chk(rx, 8'h08); // init done visible
   endtask : t_soft_reset
   task t_unmapped;
      apb(0, 8'h1c, 8'h00);
      chk({7'h0, err_seen}, 8'h01);
      chk(rx, 8'h00);
   endtask : t_unmapped
   // master write of address then one data word, run while in idle
   task t_master;
      apb(1, i2c_bus_pkg::OFS_DIV, 8'h01);
      apb(1, i2c_bus_pkg::OFS_IDLE, 8'h01);
      apb(1, i2c_bus_pkg::OFS_CTRL1, 8'h10);
      apb(1, i2c_bus_pkg::OFS_OWN, 8'h02);
      apb(1, i2c_bus_pkg::OFS_CTRL2, 8'h18); // slave receiver
      apb(1, i2c_bus_pkg::OFS_DATA, 8'ha0);
      apb(1, i2c_bus_pkg::OFS_CTRL2, 8'hf8);
      idle_in <= 1'b1;
      wait_irq(1'b0); // engine keeps running in idle
      chk(sl_byte, 8'ha0);
      apb(0, i2c_bus_pkg::OFS_STAT, 8'h00);
      chk(rx, 8'he0); // acked, busy, pending cleared
      repeat (30) @(posedge clk_in);
      chk({7'h0, oe.scl}, 8'h01); // clock held low
      apb(1, i2c_bus_pkg::OFS_DATA, 8'h5a);
      wait_irq(1'b0);
      chk(sl_byte, 8'h5a);
      apb(0, i2c_bus_pkg::OFS_STAT, 8'h00);
      chk(rx, 8'he0); // receiver wants more, so stop is software's
      apb(1, i2c_bus_pkg::OFS_CTRL2, 8'hd8);
      wait_irq(1'b1);
      apb(0, i2c_bus_pkg::OFS_STAT, 8'h00);
      chk(rx & 8'he0, 8'h00); // busy cleared on stop
   endtask : t_master
   // master read: one word with no ack clock, then a 1-bit word, stop
   task t_receive;
      apb(1, i2c_bus_pkg::OFS_CTRL1, 8'h10);
      apb(1, i2c_bus_pkg::OFS_DATA, 8'ha1);
      apb(1, i2c_bus_pkg::OFS_CTRL2, 8'hf8);
      wait_irq(1'b0);
      apb(0, i2c_bus_pkg::OFS_STAT, 8'h00);
      chk(rx, 8'ha0); // acked read: receiver now
      apb(1, i2c_bus_pkg::OFS_CTRL1, 8'h00); // no ack clock
      apb(0, i2c_bus_pkg::OFS_DATA, 8'h00); // dummy read clocks word
      wait_irq(1'b0);
      apb(1, i2c_bus_pkg::OFS_CTRL1, 8'h20);
      apb(0, i2c_bus_pkg::OFS_DATA, 8'h00);
      chk(rx, 8'hff); // released line reads ones
      wait_irq(1'b0);
      apb(0, i2c_bus_pkg::OFS_STAT, 8'h00);
      chk(rx, 8'ha1); // line left high on the 1-bit word
      apb(1, i2c_bus_pkg::OFS_CTRL2, 8'hd8);
      wait_irq(1'b1);
   endtask : t_receive
   ////////////////////////////////////////////////////////////////////
   // clock
   initial begin
      forever #5 clk_in = ~clk_in;
   end
   // main sequence
   initial begin
      repeat (20) @(posedge clk_in);
      nrst_in <= 1'b1;
      t_soft_reset();
      t_unmapped();
      t_master();
      t_receive();
      end_sim();
   end
   // watchdog cuts a hang short
   initial begin
      repeat (20000) @(posedge clk_in);
      num_errors++;
      end_sim();
   end
endmodule : i2c_bus_interface_tb
`default_nettype wire
